// ---- hw/ucr_control_regs.v ----
// Purpose: control and configuration register bank of a quadrature
//          upconverter, programmed through the device serial port
// Assumes: serial clock, chip select and data are synchronous to clock
// Notes:   control bits held in the first and second control registers arrive
//          as plain inputs
// What this block does
// - clock path bits 29:28 set reference output driver mode, reset 01b.
// - clock path bits 26:24 pick oscillator band, reset 111b.
// - clock path bits 21:19 pick charge pump current, reset 111b.
// - clock path bit 15: 0 uses input divider (reset), 1 bypasses it.
// - clock path bit 14 is active-low input divider reset, reset 1.
// - clock path bit 8: 0 bypasses PLL (reset), 1 enables it.
// - clock path bits 7:1 hold PLL feedback modulus, reset zero.
// - register 0x03 bits 7:0 set DAC full-scale current, reset 0xff.
// - update interval writes at 0x04 apply at once, no strobe needed.
// - interval sets automatic strobe spacing, only when enabled; reset 0xfffffff.
// - segment zero becomes active on select-pin rise with RAM enabled.
// - segment one becomes active on select-pin fall with RAM enabled.
// - descriptor bits 47:32 hold RAM address step rate.
// - descriptor bits 31:22 hold final RAM address.
// - descriptor bits 15:6 hold first RAM address.
// - descriptor bits 2:0 pick playback mode.
// - amplitude scale register acts only while its enable bit is 1.
// - bits 31:16 set amplitude ramp rate, only with automatic keying.
// - with both keying modes off, bits 15:2 are the amplitude directly.
// - with manual keying only, amplitude applies while keying pin is 1.
// - with automatic keying, bits 15:2 cap the ramped amplitude.
// - bits 1:0 pick ramp step size, only with automatic keying.
`timescale 1ns/1ps
`include "ucr_regs.vh"

module ucr_control_regs (
   // clock and reset
   input wire clock,
   input wire arst_n,
   // serial port
   input wire sclk,
   input wire cs_n,
   input wire sdio_in,
   output wire sdio_out,
   output wire sdio_oe,
   // strobes and pins
   input wire io_update_pin,
   input wire segment_select_pin,
   input wire amplitude_keying_pin,
   // bits of the first and second control registers
   input wire ram_enable,
   input wire amp_scale_enable,
   input wire auto_keying,
   input wire manual_keying,
   input wire auto_update_enable,
   // reference clock path
   output wire [1:0] refout_drive_mode,
   output wire [2:0] oscillator_band_select,
   output wire [2:0] charge_pump_current,
   output wire ref_divider_bypass,
   output wire ref_divider_run_n_reset,
   output wire pll_enable,
   output wire [6:0] pll_feedback_modulus,
   // main dac
   output wire [7:0] dac_full_scale,
   // update strobe seen by the rest of the device
   output wire update_strobe,
   // active ram segment
   output wire seg_active_one,
   output wire [15:0] seg_step_rate,
   output wire [9:0] seg_end_addr,
   output wire [9:0] seg_start_addr,
   output wire [2:0] seg_playback_mode,
   // amplitude scale to the synthesizer
   output wire [13:0] amplitude_scale
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   reg sclk_prev_q;
   reg [5:0] bit_cnt_q;
   reg [47:0] shift_q;
   reg [47:0] rd_shift_q;
   reg rd_mode_q;
   reg [4:0] addr_q;
   reg sdo_q;
   reg sdo_oe_q;
   reg [31:0] cp_shadow_q;
   reg [31:0] cp_active_q;
   reg [7:0] fs_shadow_q;
   reg [7:0] fs_active_q;
   reg [31:0] interval_q;
   reg [31:0] upd_cnt_q;
   reg update_q;
   reg [47:0] seg0_q;
   reg [47:0] seg1_shadow_q;
   reg [47:0] seg1_q;
   reg seg_sel_prev_q;
   reg seg_one_q;
   reg [47:0] seg_active_q;
   reg [31:0] as_shadow_q;
   reg [31:0] as_active_q;
   reg [15:0] ramp_cnt_q;
   reg [13:0] amp_q;

   // ----------------------------------------
   // serial decode
   // ----------------------------------------
   wire sclk_rise = sclk & ~sclk_prev_q;
   wire [47:0] shift_d = {shift_q[46:0], sdio_in};
   wire [7:0] instr_d = shift_d[7:0];
   wire instr_done = sclk_rise && (bit_cnt_q == (`UCR_INSTR_BITS - 6'h01));
   reg [5:0] nbytes;
   reg known_addr;
   reg [5:0] last_bit;
   wire write_done;
   wire io_update_all;


   // sclk is sampled, not used as a clock: the host must hold each sclk
   // level for at least one system clock or bits are lost.
   // a transfer is an 8-bit instruction then 4 or 6 data bytes, msb first.
   // only the latched address decides the length, so a transfer whose
   // instruction names an unmapped register shifts in harmlessly.

   // length and validity of the transfer in flight
   always @* begin
      nbytes = `UCR_BYTES_WORD;
      known_addr = 1'b1;
      if (addr_q == `UCR_ADDR_RAM_SEGMENT_ZERO) begin
         nbytes = `UCR_BYTES_SEGMENT;
      end else if (addr_q == `UCR_ADDR_RAM_SEGMENT_ONE) begin
         nbytes = `UCR_BYTES_SEGMENT;
      end else if (addr_q == `UCR_ADDR_CLOCK_PATH_CONFIG) begin
         known_addr = 1'b1;
      end else if (addr_q == `UCR_ADDR_DAC_FULL_SCALE) begin
         known_addr = 1'b1;
      end else if (addr_q == `UCR_ADDR_AUTO_UPDATE_INTERVAL) begin
         known_addr = 1'b1;
      end else if (addr_q == `UCR_ADDR_AMPLITUDE_SCALE) begin
         known_addr = 1'b1;
      end else begin
         known_addr = 1'b0;
      end
      last_bit = `UCR_INSTR_BITS + {nbytes[2:0], 3'b000} - 6'h01;
   end

   // read value must come from the instruction just completing
   reg [47:0] rd_first;
   always @* begin
      rd_first = 48'h000000000000;
      case (instr_d[4:0])
         `UCR_ADDR_CLOCK_PATH_CONFIG: rd_first = {cp_shadow_q, 16'h0000};
         `UCR_ADDR_DAC_FULL_SCALE: rd_first = {24'h000000, fs_shadow_q, 16'h0000};
         `UCR_ADDR_AUTO_UPDATE_INTERVAL: rd_first = {interval_q, 16'h0000};
         `UCR_ADDR_RAM_SEGMENT_ZERO: rd_first = seg0_q;
         `UCR_ADDR_RAM_SEGMENT_ONE: rd_first = seg1_shadow_q;
         `UCR_ADDR_AMPLITUDE_SCALE: rd_first = {as_shadow_q, 16'h0000};
         default: rd_first = 48'h000000000000;
      endcase
   end

   assign write_done = sclk_rise && !cs_n && !rd_mode_q && known_addr &&
                       (bit_cnt_q == last_bit);

   // ----------------------------------------
   // serial port shifter
   // ----------------------------------------
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         sclk_prev_q <= 1'b0;
         bit_cnt_q <= 6'h00;
         shift_q <= 48'h000000000000;
         rd_shift_q <= 48'h000000000000;
         rd_mode_q <= 1'b0;
         addr_q <= 5'h00;
         sdo_q <= 1'b0;
         sdo_oe_q <= 1'b0;
      end else begin
         sclk_prev_q <= sclk;
         if (cs_n) begin
            // deselect aborts any partial transfer
            bit_cnt_q <= 6'h00;
            rd_mode_q <= 1'b0;
            sdo_oe_q <= 1'b0;
         end else if (sclk_rise) begin
            shift_q <= shift_d;
            if (bit_cnt_q != 6'h3f) begin
               bit_cnt_q <= bit_cnt_q + 6'h01;
            end
            if (instr_done) begin
               rd_mode_q <= instr_d[`UCR_INSTR_READ_BIT];
               addr_q <= instr_d[4:0];
               sdo_oe_q <= instr_d[`UCR_INSTR_READ_BIT];
               sdo_q <= rd_first[47];
               rd_shift_q <= {rd_first[46:0], 1'b0};
            end else if (rd_mode_q) begin
               sdo_q <= rd_shift_q[47];
               rd_shift_q <= {rd_shift_q[46:0], 1'b0};
            end
         end
      end
   end

   assign sdio_out = sdo_q;
   assign sdio_oe = sdo_oe_q;

   // ----------------------------------------
   // automatic update strobe
   // ----------------------------------------
   // interval counts from the live register so a new value applies at once.
   // a strobe is due when the counter reaches the interval, so the spacing
   // is interval plus one clocks; a smaller value written mid-count fires
   // at the next edge rather than waiting for a wrap.
   // the pin request and the automatic pulse share one flop, so a pin
   // pulse landing on a due count yields a single strobe, not two.

   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         upd_cnt_q <= 32'h00000000;
         update_q <= 1'b0;
      end else begin
         update_q <= io_update_pin;
         if (!auto_update_enable) begin
            upd_cnt_q <= 32'h00000000;
         end else if (upd_cnt_q >= interval_q) begin
            upd_cnt_q <= 32'h00000000;
            update_q <= 1'b1;
         end else begin
            upd_cnt_q <= upd_cnt_q + 32'h00000001;
         end
      end
   end

   assign io_update_all = update_q;
   assign update_strobe = update_q;

   // ----------------------------------------
   // register writes and shadow transfer
   // ----------------------------------------
   // reads return the shadow side, so software sees what it wrote even
   // before the strobe; the active copy is only observable on the outputs.
   // a write and a strobe in one cycle: the strobe moves the old shadow,
   // the new value waits for the next strobe.
   // reserved bits are masked at write time so they always read zero.

   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cp_shadow_q <= `UCR_CP_RESET;
         cp_active_q <= `UCR_CP_RESET;
         fs_shadow_q <= `UCR_FS_RESET;
         fs_active_q <= `UCR_FS_RESET;
         interval_q <= `UCR_INTERVAL_RESET;
         seg0_q <= `UCR_SEG_RESET;
         seg1_shadow_q <= `UCR_SEG_RESET;
         seg1_q <= `UCR_SEG_RESET;
         as_shadow_q <= `UCR_AS_RESET;
         as_active_q <= `UCR_AS_RESET;
      end else begin
         if (write_done) begin
            if (addr_q == `UCR_ADDR_CLOCK_PATH_CONFIG) begin
               cp_shadow_q <= shift_d[31:0] & `UCR_CP_MASK;
            end else if (addr_q == `UCR_ADDR_DAC_FULL_SCALE) begin
               fs_shadow_q <= shift_d[`UCR_FS_FIELD];
            end else if (addr_q == `UCR_ADDR_AUTO_UPDATE_INTERVAL) begin
               interval_q <= shift_d[31:0];
            end else if (addr_q == `UCR_ADDR_RAM_SEGMENT_ZERO) begin
               seg0_q <= shift_d & `UCR_SEG_MASK;
            end else if (addr_q == `UCR_ADDR_RAM_SEGMENT_ONE) begin
               seg1_shadow_q <= shift_d & `UCR_SEG_MASK;
            end else begin
               as_shadow_q <= shift_d[31:0];
            end
         end
         if (io_update_all) begin
            cp_active_q <= cp_shadow_q;
            fs_active_q <= fs_shadow_q;
            seg1_q <= seg1_shadow_q;
            as_active_q <= as_shadow_q;
         end
      end
   end

   assign refout_drive_mode = cp_active_q[`UCR_CP_DRIVE];
   assign oscillator_band_select = cp_active_q[`UCR_CP_BAND];
   assign charge_pump_current = cp_active_q[`UCR_CP_PUMP];
   assign ref_divider_bypass = cp_active_q[`UCR_CP_DIV_BYPASS];
   assign ref_divider_run_n_reset = cp_active_q[`UCR_CP_DIV_RUN];
   assign pll_enable = cp_active_q[`UCR_CP_PLL_ENABLE];
   assign pll_feedback_modulus = cp_active_q[`UCR_CP_MODULUS];
   assign dac_full_scale = fs_active_q;

   // ----------------------------------------
   // ram segment selection
   // ----------------------------------------
   // segment zero is live, so a rise loads whatever was last written;
   // segment one only offers what the last strobe moved across.
   // the pin is compared with its own previous sample, so the flop resets
   // low to match the idle level and no false rise follows reset.
   // with ram disabled the edge history still tracks the pin, so enabling
   // ram later does not replay an old edge.

   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         seg_sel_prev_q <= 1'b0;
         seg_one_q <= 1'b0;
         seg_active_q <= `UCR_SEG_RESET;
      end else begin
         seg_sel_prev_q <= segment_select_pin;
         if (ram_enable && segment_select_pin && !seg_sel_prev_q) begin
            seg_one_q <= 1'b0;
            seg_active_q <= seg0_q;
         end else if (ram_enable && !segment_select_pin && seg_sel_prev_q) begin
            seg_one_q <= 1'b1;
            seg_active_q <= seg1_q;
         end
      end
   end

   assign seg_active_one = seg_one_q;
   assign seg_step_rate = seg_active_q[`UCR_SEG_STEP_RATE];
   assign seg_end_addr = seg_active_q[`UCR_SEG_END_ADDR];
   assign seg_start_addr = seg_active_q[`UCR_SEG_START_ADDR];
   assign seg_playback_mode = seg_active_q[`UCR_SEG_MODE];

   // ----------------------------------------
   // amplitude scale
   // ----------------------------------------
   // step codes 0 to 3 give steps of 1, 2, 4 and 8.
   // a tick comes every rate plus one clocks while automatic keying runs;
   // the ramp counter idles at zero otherwise so the first tick is full length.
   // a ceiling lowered below the present amplitude clamps at once instead
   // of walking down, trading smoothness for never exceeding the limit.
   // ramping down stops at zero rather than wrapping.

   wire [13:0] as_ceiling = as_active_q[`UCR_AS_SCALE];
   wire [15:0] as_rate = as_active_q[`UCR_AS_RAMP_RATE];
   wire [1:0] as_step_code = as_active_q[`UCR_AS_STEP];
   wire [14:0] as_step = 15'h0001 << as_step_code;
   wire [14:0] amp_up = {1'b0, amp_q} + as_step;
   wire ramp_tick = (ramp_cnt_q >= as_rate);
   reg [13:0] amp_d;

   always @* begin
      amp_d = amp_q;
      if (!amp_scale_enable) begin
         amp_d = `UCR_AS_FULL_SCALE;
      end else if (!auto_keying && !manual_keying) begin
         amp_d = as_ceiling;
      end else if (!auto_keying) begin
         amp_d = amplitude_keying_pin ? as_ceiling : 14'h0000;
      end else if (amp_q > as_ceiling) begin
         amp_d = as_ceiling;
      end else if (ramp_tick && amplitude_keying_pin) begin
         // saturate at the ceiling instead of wrapping past it
         amp_d = (amp_up >= {1'b0, as_ceiling}) ? as_ceiling : amp_up[13:0];
      end else if (ramp_tick) begin
         amp_d = ({1'b0, amp_q} <= as_step) ? 14'h0000 : amp_q - as_step[13:0];
      end
   end

   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ramp_cnt_q <= 16'h0000;
         amp_q <= `UCR_AS_FULL_SCALE;
      end else begin
         amp_q <= amp_d;
         if (!auto_keying || !amp_scale_enable || ramp_tick) begin
            ramp_cnt_q <= 16'h0000;
         end else begin
            ramp_cnt_q <= ramp_cnt_q + 16'h0001;
         end
      end
   end

   assign amplitude_scale = amp_q;

endmodule // ucr_control_regs

// ---- inc/ucr_regs.vh ----
// Purpose: register offsets, field positions, masks and reset values of the
//          upconverter control register bank
// Assumes: included by hw/ucr_control_regs.v only
// Notes:   definitions only
`ifndef UCR_REGS_VH
`define UCR_REGS_VH

// ----------------------------------------
// register addresses (serial port instruction bits 4:0)
// ----------------------------------------
`define UCR_ADDR_CLOCK_PATH_CONFIG 5'h02
`define UCR_ADDR_DAC_FULL_SCALE 5'h03
`define UCR_ADDR_AUTO_UPDATE_INTERVAL 5'h04
`define UCR_ADDR_RAM_SEGMENT_ZERO 5'h05
`define UCR_ADDR_RAM_SEGMENT_ONE 5'h06
`define UCR_ADDR_AMPLITUDE_SCALE 5'h09

// ----------------------------------------
// serial port framing
// ----------------------------------------
`define UCR_INSTR_BITS 6'h08
`define UCR_INSTR_READ_BIT 7
`define UCR_BYTES_WORD 6'h04
`define UCR_BYTES_SEGMENT 6'h06

// ----------------------------------------
// clock_path_config fields
// ----------------------------------------
`define UCR_CP_DRIVE 29:28
`define UCR_CP_BAND 26:24
`define UCR_CP_PUMP 21:19
`define UCR_CP_DIV_BYPASS 15
`define UCR_CP_DIV_RUN 14
`define UCR_CP_PLL_ENABLE 8
`define UCR_CP_MODULUS 7:1
`define UCR_CP_MASK 32'h3738c1fe
`define UCR_CP_RESET 32'h17384000

// ----------------------------------------
// dac_full_scale_control
// ----------------------------------------
`define UCR_FS_FIELD 7:0
`define UCR_FS_RESET 8'hff

// ----------------------------------------
// auto_update_interval
// ----------------------------------------
`define UCR_INTERVAL_RESET 32'h0fffffff

// ----------------------------------------
// ram segment descriptor fields
// ----------------------------------------
`define UCR_SEG_STEP_RATE 47:32
`define UCR_SEG_END_ADDR 31:22
`define UCR_SEG_START_ADDR 15:6
`define UCR_SEG_MODE 2:0
`define UCR_SEG_MASK 48'hffffffc0ffc7
`define UCR_SEG_RESET 48'h000000000000

// ----------------------------------------
// amplitude_scale_control fields
// ----------------------------------------
`define UCR_AS_RAMP_RATE 31:16
`define UCR_AS_SCALE 15:2
`define UCR_AS_STEP 1:0
`define UCR_AS_RESET 32'h00000000
`define UCR_AS_FULL_SCALE 14'h3fff

`endif

// ---- testbench/ucr_control_regs_checker.sv ----
// Purpose: temporal checks on the register bank ports
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bound to the bank at the foot of this file
`timescale 1ns/1ps
module ucr_checker (
   // clock and reset
   input wire clock,
   input wire arst_n,
   // pins and mode bits
   input wire io_update_pin,
   input wire segment_select_pin,
   input wire amplitude_keying_pin,
   input wire ram_enable,
   input wire amp_scale_enable,
   input wire auto_keying,
   input wire manual_keying,
   input wire auto_update_enable,
   // watched outputs
   input wire [7:0] dac_full_scale,
   input wire update_strobe,
   input wire seg_active_one,
   input wire [13:0] amplitude_scale
);
   wire direct = amp_scale_enable && !auto_keying && !manual_keying;
   wire gated = amp_scale_enable && !auto_keying && manual_keying && !amplitude_keying_pin;
   default clocking dcb @(posedge clock); endclocking
   default disable iff (!arst_n);
   // ----
   // assertions
   // ----
   chk_strobe_pin: assert property (io_update_pin |=> update_strobe)
      else $error("no strobe after update pin");
   chk_strobe_idle: assert property (
      !io_update_pin && !auto_update_enable |=> !update_strobe)
      else $error("strobe without cause");
   chk_seg_rise: assert property (
      ram_enable && $rose(segment_select_pin) |-> ##[1:2] !seg_active_one)
      else $error("segment zero not selected");
   chk_seg_fall: assert property (
      ram_enable && $fell(segment_select_pin) |-> ##[1:2] seg_active_one)
      else $error("segment one not selected");
   chk_seg_frozen: assert property ((!ram_enable) [*3] |=> $stable(seg_active_one))
      else $error("segment moved with ram off");
   chk_amp_off: assert property (
      (!amp_scale_enable) [*2] |=> amplitude_scale == 14'h3fff)
      else $error("amplitude not full scale when off");
   chk_amp_gated: assert property (gated [*2] |=> amplitude_scale == 14'h0)
      else $error("amplitude not zero with keying pin low");
   chk_amp_direct: assert property (
      (direct && !update_strobe) [*2] |=> $stable(amplitude_scale))
      else $error("direct amplitude moved without strobe");
   chk_dac_hold: assert property (!update_strobe |=> $stable(dac_full_scale))
      else $error("full scale moved without strobe");
   cov_seg_rise: cover property (ram_enable && $rose(segment_select_pin));
   cov_auto: cover property (auto_update_enable && update_strobe && !$past(io_update_pin));
   cov_ramp_top: cover property (auto_keying && amplitude_scale == 14'd48);
endmodule // ucr_checker

bind ucr_control_regs ucr_checker ucr_checker_i (.clock(clock), .arst_n(arst_n),
   .io_update_pin(io_update_pin), .segment_select_pin(segment_select_pin),
   .amplitude_keying_pin(amplitude_keying_pin), .ram_enable(ram_enable),
   .amp_scale_enable(amp_scale_enable), .auto_keying(auto_keying),
   .manual_keying(manual_keying), .auto_update_enable(auto_update_enable),
   .dac_full_scale(dac_full_scale), .update_strobe(update_strobe),
   .seg_active_one(seg_active_one), .amplitude_scale(amplitude_scale));

// ---- testbench/ucr_control_regs_tb.sv ----
// Purpose: self-checking bench for the register bank
// Assumes: serial port bit-banged from the falling clock edge
// Notes: a shadow/active model decides the expected register, segment, direct and manual amplitude values
`timescale 1ns/1ps
module ucr_control_regs_tb;
   logic clock = 0, arst_n = 0, sclk = 0, cs_n = 1, sdio_in = 0, io_update_pin = 0;
   logic segment_select_pin = 0, amplitude_keying_pin = 0, ram_enable = 0;
   logic amp_scale_enable = 0, auto_keying = 0, manual_keying = 0, auto_update_enable = 0;
   wire sdio_out, sdio_oe, update_strobe, seg_active_one, pll_enable;
   wire ref_divider_bypass, ref_divider_run_n_reset;
   wire [1:0] refout_drive_mode;
   wire [2:0] oscillator_band_select, charge_pump_current, seg_playback_mode;
   wire [6:0] pll_feedback_modulus;
   wire [7:0] dac_full_scale;
   wire [15:0] seg_step_rate;
   wire [9:0] seg_end_addr, seg_start_addr;
   wire [13:0] amplitude_scale;
   int n_mismatch = 0, checks_done = 0, n;
   logic [47:0] shd [0:31], act [0:31], rd;
   logic [4:0] adr [0:6] = '{5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h09, 5'h07};
   ucr_control_regs ucr_control_regs_i (.clock(clock), .arst_n(arst_n), .sclk(sclk),
      .cs_n(cs_n), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
      .io_update_pin(io_update_pin), .segment_select_pin(segment_select_pin),
      .amplitude_keying_pin(amplitude_keying_pin), .ram_enable(ram_enable),
      .amp_scale_enable(amp_scale_enable), .auto_keying(auto_keying),
      .manual_keying(manual_keying), .auto_update_enable(auto_update_enable),
      .refout_drive_mode(refout_drive_mode), .oscillator_band_select(oscillator_band_select),
      .charge_pump_current(charge_pump_current), .ref_divider_bypass(ref_divider_bypass),
      .ref_divider_run_n_reset(ref_divider_run_n_reset), .pll_enable(pll_enable),
      .pll_feedback_modulus(pll_feedback_modulus), .dac_full_scale(dac_full_scale),
      .update_strobe(update_strobe), .seg_active_one(seg_active_one),
      .seg_step_rate(seg_step_rate), .seg_end_addr(seg_end_addr),
      .seg_start_addr(seg_start_addr), .seg_playback_mode(seg_playback_mode),
      .amplitude_scale(amplitude_scale));
   always #20 clock = ~clock;
   // ----
   // helpers
   // ----
   task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   function automatic logic [47:0] msk(input logic [4:0] a);
      case (a)
         5'h02: msk = 48'h3738c1fe;
         5'h03: msk = 48'hff;
         5'h04, 5'h09: msk = 48'hffffffff;
         5'h05, 5'h06: msk = 48'hffffffc0ffc7;
         default: msk = 48'h0;
      endcase
   endfunction
   function automatic logic [47:0] rnd();
      rnd = {16'($urandom), $urandom};
   endfunction
   // host drives bits low-then-high; read bits are taken before each rise
   task automatic xfer(input logic [7:0] ins, input logic [47:0] wd, output logic [47:0] r);
      int nb;
      nb = (ins[4:0] == 5'h05 || ins[4:0] == 5'h06) ? 48 : 32;
      r = 48'h0;
      @(negedge clock) cs_n = 0;
      for (int i = 0; i < 8 + nb; i++) begin
         @(negedge clock) sclk = 0;
         if (i >= 8) r = {r[46:0], sdio_out};
         sdio_in = (i < 8) ? ins[7 - i] : wd[nb + 7 - i];
         @(negedge clock) sclk = 1;
      end
      @(negedge clock) sclk = 0;
      chk(sdio_oe, ins[7], "oe");
      @(negedge clock) cs_n = 1;
      @(negedge clock);
   endtask
   task automatic wr(input logic [4:0] a, input logic [47:0] d);
      xfer({3'h0, a}, d, rd);
      shd[a] = d & msk(a);
      if (a == 5'h04 || a == 5'h05) act[a] = shd[a];
   endtask
   task automatic upd();
      @(negedge clock) io_update_pin = 1;
      @(negedge clock) io_update_pin = 0;
      repeat (3) @(negedge clock);
      act = shd;
   endtask
   task automatic cmp_out();
      chk(refout_drive_mode, act[2][29:28], "drive");
      chk(oscillator_band_select, act[2][26:24], "band");
      chk(charge_pump_current, act[2][21:19], "pump");
      chk(ref_divider_bypass, act[2][15], "bypass");
      chk(ref_divider_run_n_reset, act[2][14], "run");
      chk(pll_enable, act[2][8], "pll");
      chk(pll_feedback_modulus, act[2][7:1], "modulus");
      chk(dac_full_scale, act[3][7:0], "fsc");
   endtask
   task automatic seg(input logic v, input logic [47:0] s, input logic one);
      @(negedge clock) segment_select_pin = v;
      repeat (3) @(negedge clock);
      chk(seg_active_one, one, "active");
      chk(seg_step_rate, s[47:32], "rate");
      chk(seg_end_addr, s[31:22], "end");
      chk(seg_start_addr, s[15:6], "start");
      chk(seg_playback_mode, s[2:0], "mode");
   endtask
   task automatic ramp(input logic [13:0] tgt, input logic [13:0] stp, input int per);
      logic [13:0] p;
      int gap;
      bit seen, ok;
      p = amplitude_scale;
      gap = 0;
      seen = 0;
      repeat (300) begin
         @(negedge clock);
         gap++;
         chk(amplitude_scale > 14'd48, 1'b0, "ceiling");
         if (amplitude_scale !== p) begin
            ok = amplitude_scale == p + stp || amplitude_scale == p - stp;
            chk(ok || amplitude_scale == 14'd48, 1'b1, "step");
            if (seen) chk(gap, per, "tick");
            seen = 1;
            gap = 0;
            p = amplitude_scale;
         end
      end
      chk(amplitude_scale, tgt, "limit");
   endtask
   task automatic wait_strobe(output int k);
      k = 0;
      do begin
         @(negedge clock);
         k++;
      end while (update_strobe !== 1'b1 && k < 1000);
      if (k >= 1000) begin
         chk(1'b0, 1'b1, "strobe timeout");
         summarize();
      end
   endtask
   // ----
   // stimulus
   // ----
   initial begin
      void'($urandom(6124));
      foreach (shd[i]) shd[i] = 48'h0;
      shd[2] = 48'h17384000;
      shd[3] = 48'hff;
      shd[4] = 48'h0fffffff;
      act = shd;
      repeat (16) @(posedge clock);
      @(negedge clock) arst_n = 1;
      cmp_out();
      chk(amplitude_scale, 14'h3fff, "amp off");
      foreach (adr[k]) begin
         xfer({3'h4, adr[k]}, 48'h0, rd);
         chk(rd, shd[adr[k]], "reset read");
      end
      $display("test reset done");
      repeat (3) begin
         foreach (adr[k]) wr(adr[k], rnd());
         cmp_out();
         foreach (adr[k]) begin
            xfer({3'h4, adr[k]}, 48'h0, rd);
            chk(rd, shd[adr[k]], "readback");
         end
         upd();
         cmp_out();
      end
      $display("test registers done");
      seg(1'b1, 48'h0, 1'b0);
      seg(1'b0, 48'h0, 1'b0);
      ram_enable = 1;
      repeat (2) begin
         seg(1'b1, shd[5], 1'b0);
         seg(1'b0, act[6], 1'b1);
         wr(5'h05, rnd());
         wr(5'h06, rnd());
      end
      $display("test segments done");
      amp_scale_enable = 1;
      wr(5'h09, rnd());
      upd();
      chk(amplitude_scale, act[9][15:2], "direct");
      manual_keying = 1;
      repeat (6) begin
         amplitude_keying_pin = 1'($urandom);
         repeat (2) @(negedge clock);
         chk(amplitude_scale, amplitude_keying_pin ? act[9][15:2] : 14'h0, "manual");
      end
      auto_keying = 1;
      for (int c = 0; c < 4; c++) begin
         wr(5'h09, {16'h0, 16'(c + 2), 14'd48, 2'(c)});
         upd();
         amplitude_keying_pin = 1;
         ramp(14'd48, 14'd1 << c, c + 3);
         amplitude_keying_pin = 0;
         ramp(14'd0, 14'd1 << c, c + 3);
      end
      $display("test amplitude done");
      wr(5'h04, 48'd9);
      auto_update_enable = 1;
      wait_strobe(n);
      wait_strobe(n);
      chk(n, 10, "interval");
      auto_update_enable = 0;
      n = 0;
      repeat (30) begin
         @(negedge clock);
         if (update_strobe !== 1'b0) n++;
      end
      chk(n, 0, "auto off");
      $display("test auto update done");
      summarize();
   end
endmodule // ucr_control_regs_tb
